// File: sbt_pkg.sv
/*
  sbt_pkg: shared constants, register map, carrier types and master
  sequencer states of the serial byte transfer engine.
  Assumes a single 10 MHz system clock and open-drain pins resolved outside.
*/
// Operation
// - bytes leave on the data line most significant bit first
// - first received bit ends up in bit 7 of the byte register
// - bus data shifts in while shifting out; register holds last bus byte
// - lost arbitration turns master transmitter into slave receiver, byte kept
// - master from generated START until arbitration loss or generated STOP
// - event per byte; receiver before acknowledge, transmitter after it
// - master write sends START, address with direction 0, then acknowledged data
// - master transfer ends on arbitration loss, or else only after stop request flag set, then STOP
// - no byte register write after master transmit event gives master receiver
// - master read sends address with direction 1, clocks in slave data
// - master receiver sets ack request flag and event after every byte
// - ack bit 1 sends acknowledge, 0 sends no-acknowledge; 0 for last byte
// - master receiver ends on STOP; byte register write gives master transmitter
// - slave inhibit 0: START plus address gives slave receiver, event, ack request
// - no-acknowledged slave address mutes slave events until next START
// - slave receiver ends on STOP; byte register write gives slave transmitter
// - no write after slave transmit event gives slave receiver; STOP ends it
// - event flag set holds clock line low and stalls the bus
// - writing 0 to event flag clears it and resumes; writing 1 forces it
package sbt_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SHIFT = 8'hc2;
    localparam logic [7:0] ADDR_CTRL = 8'hc0;
    localparam logic [7:0] RST_SHIFT = 8'h00;
    localparam logic [7:0] RST_READ = 8'h00;
    localparam int B_MASTER = 7;
    localparam int B_TXMODE = 6;
    localparam int B_STA = 5;
    localparam int B_STO = 4;
    localparam int B_ACK_REQUEST_FLAG = 3;
    localparam int B_ARBLOST = 2;
    localparam int B_ACK = 1;
    localparam int B_SI = 0;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_PERIOD_NS = 800;
    localparam int SCL_HALF_RAW = SCL_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int SCL_HALF_CYC = (SCL_HALF_RAW < 1) ? 1 : SCL_HALF_RAW;
    localparam int RX_FIFO_DEPTH = 16;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sbt_sfr_req_t;
    typedef enum logic [2:0] {
        M_IDLE,
        M_START_A,
        M_START_B,
        M_RUN,
        M_RS,
        M_STOP_A,
        M_STOP_B,
        M_STOP_C
    } sbt_mstate_t;
endpackage

// File: sbt_fifo.sv
/*
  sbt_fifo: synchronous valid/ready buffer of WIDTH x DEPTH words.
  Assumes one clock and synchronous active-high reset; DEPTH at least 2.
*/
`timescale 1ns/1ps
`default_nettype none

module sbt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // system
    input wire logic clock,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    wire logic push;
    wire logic pop;

    assign inReady = (count != FULL);
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + AW'(1);
            end
            if (pop) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW + 1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW + 1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// File: sbt_smbus.sv
/*
  sbt_smbus: byte transfer engine of a two-wire serial interface: shift
  register, transfer mode flags, master clock sequencer, receive stream.
  Assumes one clock, pins resolved outside as open drain, firmware access
  through the special function register port.
*/
`timescale 1ns/1ps
`default_nettype none

module sbt_smbus #(
    parameter int FIFO_DEPTH = sbt_pkg::RX_FIFO_DEPTH
) (
    // system
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire sbt_pkg::sbt_sfr_req_t sfrReq,
    output logic [7:0] sfrRdData,
    // loose control and status
    input wire logic enable,
    input wire logic slaveInhibit,
    output logic addrReadDir,
    // bus pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // receive stream
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] rxByte
);
    localparam logic [7:0] HALF_M1 = 8'(sbt_pkg::SCL_HALF_CYC - 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclP;
    logic sdaP;
    logic [7:0] sh;
    logic txBit;
    logic ackIn;
    logic si;
    logic master;
    logic txmode;
    logic start_request_flag;
    logic stop_request_flag;
    logic ack_request_flag;
    logic arblost;
    logic ack;
    logic wrote;
    logic busBusy;
    logic skipFall;
    logic [3:0] bitCnt;
    logic addrPhase;
    logic addressed;
    logic ignore;
    logic stallLow;
    logic mSclLow;
    logic mSdaLow;
    logic [7:0] tickCnt;
    logic fifoInReady;
    sbt_pkg::sbt_mstate_t state;
    sbt_pkg::sbt_mstate_t next_state;
    logic next_sclLow;
    logic next_sdaLow;

    // ----------------------------------------------------------------
    // decode and events
    // ----------------------------------------------------------------
    wire logic sclS = sclSync[1];
    wire logic sdaS = sdaSync[1];
    wire logic sclRise = sclS && !sclP;
    wire logic sclFall = !sclS && sclP;
    wire logic startDet = sclS && sclP && sdaP && !sdaS;
    wire logic stopDet = sclS && sclP && !sdaP && sdaS;
    wire logic tick = (tickCnt == 8'h00);
    wire logic wrShift = sfrReq.wr && (sfrReq.addr == sbt_pkg::ADDR_SHIFT);
    wire logic wrCtrl = sfrReq.wr && (sfrReq.addr == sbt_pkg::ADDR_CTRL);
    wire logic siForce = wrCtrl && sfrReq.wdata[sbt_pkg::B_SI];
    wire logic siClr = wrCtrl && !sfrReq.wdata[sbt_pkg::B_SI] && si;
    wire logic edgeOk = busBusy && !si && !skipFall;
    wire logic involved = master || addressed || (addrPhase && !ignore && !slaveInhibit);
    wire logic byteDone = edgeOk && sclFall && (bitCnt == 4'h7);
    wire logic ackDone = edgeOk && sclFall && (bitCnt == 4'h8);
    wire logic rxByteEv = byteDone && !txmode && involved;
    wire logic txAckEv = ackDone && txmode && involved && !ack_request_flag;
    wire logic txOn = involved && txmode && edgeOk && (bitCnt < 4'h8);
    wire logic arbLose = master && txOn && sclRise && txBit && !sdaS;
    wire logic stopRx = stopDet && addressed;
    wire logic genIdle = (state == sbt_pkg::M_IDLE) && !master;
    wire logic slaveStart = startDet && genIdle;
    wire logic mStartEv = tick && (state == sbt_pkg::M_START_B);
    wire logic stopDone = tick && (state == sbt_pkg::M_STOP_C) && sclS;
    wire logic siSet = rxByteEv || txAckEv || arbLose || stopRx || mStartEv || siForce;
    wire logic siClrEff = siClr && !siSet;
    wire logic shTop = sh[7];
    wire logic [3:0] next_bitCnt = (bitCnt == 4'h8) ? 4'h0 : 4'(bitCnt + 4'h1);
    wire logic txDrive = txOn && !txBit && (!master || state == sbt_pkg::M_RUN);
    wire logic ackDrive = involved && ack_request_flag && edgeOk && (bitCnt == 4'h8) && ack;
    wire logic [7:0] ctrlVal;
    wire logic [7:0] rdSel;

    assign ctrlVal[sbt_pkg::B_MASTER] = master;
    assign ctrlVal[sbt_pkg::B_TXMODE] = txmode;
    assign ctrlVal[sbt_pkg::B_STA] = start_request_flag;
    assign ctrlVal[sbt_pkg::B_STO] = stop_request_flag;
    assign ctrlVal[sbt_pkg::B_ACK_REQUEST_FLAG] = ack_request_flag;
    assign ctrlVal[sbt_pkg::B_ARBLOST] = arblost;
    assign ctrlVal[sbt_pkg::B_ACK] = ack;
    assign ctrlVal[sbt_pkg::B_SI] = si;
    assign rdSel = (sfrReq.addr == sbt_pkg::ADDR_SHIFT) ? sh :
                   (sfrReq.addr == sbt_pkg::ADDR_CTRL) ? ctrlVal : sbt_pkg::RST_READ;
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = mSclLow || si || stallLow;
    assign sdaOe = mSdaLow || txDrive || ackDrive;

    // ----------------------------------------------------------------
    // pin sampling and register read
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        sclSync <= {sclSync[0], sclIn};
        sdaSync <= {sdaSync[0], sdaIn};
        sclP <= sclS;
        sdaP <= sdaS;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sfrRdData <= sbt_pkg::RST_READ;
        end else if (sfrReq.rd) begin
            sfrRdData <= rdSel;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || tick) begin
            tickCnt <= HALF_M1;
        end else begin
            tickCnt <= tickCnt - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // frame and bit tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || !enable) begin
            busBusy <= 1'b0;
            skipFall <= 1'b0;
            bitCnt <= 4'h0;
        end else if (startDet) begin
            busBusy <= 1'b1;
            skipFall <= 1'b1;
            bitCnt <= 4'h0;
        end else if (stopDet) begin
            busBusy <= 1'b0;
        end else if (sclFall && busBusy) begin
            skipFall <= 1'b0;
            if (edgeOk) begin
                bitCnt <= next_bitCnt;
            end
        end
    end

    // ----------------------------------------------------------------
    // shift register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            sh <= sbt_pkg::RST_SHIFT;
        end else if (wrShift) begin
            sh <= sfrReq.wdata;
        end else if (sclRise && edgeOk && bitCnt < 4'h8) begin
            sh <= {sh[6:0], sdaS};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            txBit <= 1'b1;
            ackIn <= 1'b1;
        end else begin
            if (wrShift) begin
                txBit <= sfrReq.wdata[7];
            end else if (sclFall && busBusy && !si) begin
                txBit <= sh[7];
            end
            if (sclRise && edgeOk && bitCnt == 4'h8) begin
                ackIn <= sdaS;
            end
        end
    end

    // ----------------------------------------------------------------
    // event, acknowledge and request flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            si <= 1'b0;
            arblost <= 1'b0;
            ack_request_flag <= 1'b0;
        end else begin
            si <= siSet ? 1'b1 : (siClr ? 1'b0 : si);
            arblost <= arbLose ? 1'b1 : (siClrEff ? 1'b0 : arblost);
            ack_request_flag <= rxByteEv ? 1'b1 : (ackDone ? 1'b0 : ack_request_flag);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack <= 1'b0;
            start_request_flag <= 1'b0;
            stop_request_flag <= 1'b0;
        end else begin
            if (txAckEv) begin
                ack <= !ackIn;
            end else if (wrCtrl) begin
                ack <= sfrReq.wdata[sbt_pkg::B_ACK];
            end
            if (rxByteEv && addrPhase) begin
                start_request_flag <= 1'b1;
            end else if (wrCtrl) begin
                start_request_flag <= sfrReq.wdata[sbt_pkg::B_STA];
            end
            if (stopRx) begin
                stop_request_flag <= 1'b1;
            end else if (stopDone) begin
                stop_request_flag <= 1'b0;
            end else if (wrCtrl) begin
                stop_request_flag <= sfrReq.wdata[sbt_pkg::B_STO];
            end
        end
    end

    // ----------------------------------------------------------------
    // transfer mode
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            master <= 1'b0;
            txmode <= 1'b0;
            wrote <= 1'b0;
        end else begin
            if (mStartEv) begin
                master <= 1'b1;
            end else if (arbLose || stopDone) begin
                master <= 1'b0;
            end
            if (mStartEv) begin
                txmode <= 1'b1;
            end else if (arbLose || slaveStart || stopDet) begin
                txmode <= 1'b0;
            end else if (siClrEff) begin
                txmode <= wrote || wrShift;
            end
            wrote <= siClrEff ? 1'b0 : (wrote || wrShift);
        end
    end

    // ----------------------------------------------------------------
    // slave addressing
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || !enable) begin
            addrPhase <= 1'b0;
            addressed <= 1'b0;
            ignore <= 1'b0;
            addrReadDir <= 1'b0;
        end else if (slaveStart || arbLose) begin
            addrPhase <= 1'b1;
            addressed <= 1'b0;
            ignore <= 1'b0;
        end else if (stopDet) begin
            addrPhase <= 1'b0;
            addressed <= 1'b0;
        end else if (ackDone && addrPhase) begin
            addrPhase <= 1'b0;
            addressed <= involved && ack && !master;
            ignore <= !(involved && ack);
        end else if (byteDone && addrPhase) begin
            addrReadDir <= sh[0];
        end
    end

    // ----------------------------------------------------------------
    // master sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_sclLow = mSclLow;
        next_sdaLow = mSdaLow;
        case (state)
            sbt_pkg::M_IDLE: begin
                if (start_request_flag && !si && enable && !busBusy && sclS && sdaS) begin
                    next_state = sbt_pkg::M_START_A;
                end
            end
            sbt_pkg::M_START_A: begin
                next_sdaLow = 1'b1;
                next_state = sbt_pkg::M_START_B;
            end
            sbt_pkg::M_START_B: begin
                next_sclLow = 1'b1;
                next_state = sbt_pkg::M_RUN;
            end
            sbt_pkg::M_RUN: begin
                if (mSdaLow) begin
                    next_sdaLow = 1'b0;
                end else if (si || stallLow) begin
                    next_sclLow = mSclLow;
                end else if (bitCnt == 4'h0 && mSclLow && !skipFall && stop_request_flag) begin
                    next_state = sbt_pkg::M_STOP_A;
                end else if (bitCnt == 4'h0 && mSclLow && !skipFall && start_request_flag) begin
                    next_state = sbt_pkg::M_RS;
                end else if (mSclLow) begin
                    next_sclLow = 1'b0;
                end else if (sclS) begin
                    next_sclLow = 1'b1;
                end
            end
            sbt_pkg::M_RS: begin
                if (mSclLow) begin
                    next_sclLow = 1'b0;
                end else if (sclS && sdaS) begin
                    next_state = sbt_pkg::M_START_A;
                end
            end
            sbt_pkg::M_STOP_A: begin
                next_sdaLow = 1'b1;
                next_state = sbt_pkg::M_STOP_B;
            end
            sbt_pkg::M_STOP_B: begin
                next_sclLow = 1'b0;
                next_state = sbt_pkg::M_STOP_C;
            end
            sbt_pkg::M_STOP_C: begin
                if (sclS) begin
                    next_sdaLow = 1'b0;
                    next_state = sbt_pkg::M_IDLE;
                end
            end
            default: begin
                next_state = sbt_pkg::M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst || !enable || arbLose) begin
            state <= sbt_pkg::M_IDLE;
            mSclLow <= 1'b0;
            mSdaLow <= 1'b0;
        end else if (tick) begin
            state <= next_state;
            mSclLow <= next_sclLow;
            mSdaLow <= next_sdaLow;
        end
    end

    // ----------------------------------------------------------------
    // receive stream with bus stall on full
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            stallLow <= 1'b0;
        end else begin
            stallLow <= !fifoInReady && (stallLow || !sclS);
        end
    end

    sbt_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rxFifo (
        .clock(clock),
        .rst(rst),
        .inValid(rxByteEv),
        .inReady(fifoInReady),
        .inData(sh),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxByte)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_si_stalls_scl: assert property (si [*4] |-> !sclRise)
        else $error("clock edge seen while event flag held");
    a_reg_stable: assert property (si && !wrShift |=> $stable(sh))
        else $error("byte register moved while event flag set");
    a_shift_in_msb: assert property (sclRise && edgeOk && bitCnt < 4'h8 && !wrShift
        |=> sh == 8'({$past(sh), $past(sdaS)}))
        else $error("received bit not shifted in at bit 0");
    a_tx_msb_first: assert property (sclFall && busBusy && !si && !wrShift
        |=> txBit == $past(shTop))
        else $error("transmit bit not taken from bit 7");
    a_start_master: assert property (mStartEv && !arbLose |=> master && si && txmode)
        else $error("generated start did not enter master transmitter");
    a_rx_irq_first: assert property (rxByteEv |=> si && ack_request_flag && bitCnt == 4'h8)
        else $error("receive event not raised before acknowledge");
    a_tx_irq_after: assert property (txAckEv |=> si && bitCnt == 4'h0 && ack != $past(ackIn))
        else $error("transmit event not raised after acknowledge");
    a_ack_drive: assert property (ackDrive |-> sdaOe ##1 (!sclRise || sdaOe))
        else $error("acknowledge not driven low");
    a_no_write_rx: assert property (siClrEff && !wrote && !wrShift && !startDet
        |=> !txmode)
        else $error("no write did not switch to receiver");
    a_write_tx: assert property (siClrEff && (wrote || wrShift) && !arbLose && !startDet
        && !stopDet |=> txmode)
        else $error("write did not switch to transmitter");
    a_arb_slave: assert property (arbLose |=> !master && !txmode && arblost && addrPhase)
        else $error("lost arbitration not turned into slave receiver");
    a_stop_ends: assert property (stopDone |=> !master && !stop_request_flag ##1 state == sbt_pkg::M_IDLE)
        else $error("stop did not leave master");
    a_nack_mute: assert property (ackDone && addrPhase && !ack |=> ignore && !addressed)
        else $error("refused address did not mute slave");
    a_slave_addr: assert property (rxByteEv && addrPhase |=> start_request_flag && ack_request_flag && si)
        else $error("slave address event missing");
    a_force_si: assert property (siForce |=> si)
        else $error("forced event flag not set");

    c_master_start: cover property (mStartEv);
    c_rx_byte: cover property (rxByteEv && !master);
    c_arb_lost: cover property (arbLose);
    c_stop_rx: cover property (stopRx);
endmodule
`default_nettype wire

// File: sbt_slave_model.sv
/*
  sbt_slave_model: behavioural bus target; acks every byte it receives,
  sends TXBYTE when read. Assumes pull-ups on both lines outside.
*/
`timescale 1ns/1ps
`default_nettype none
module sbt_slave_model #(
    parameter logic [7:0] TXBYTE = 8'h96
) (
    // bus
    input wire logic scl,
    input wire logic sda,
    output logic sdaLow,
    // observed
    output logic [7:0] got
);
    int n;
    logic rd, first;
    logic [7:0] sh;
    initial begin
        n = 0;
        rd = 0;
        first = 1;
        sdaLow = 0;
        sh = 8'h00;
        got = 8'h00;
    end
    // start resets framing
    always @(negedge sda) if (scl) begin
        n = 0;
        rd = 0;
        first = 1;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        if (n == 8) first = 0;
        n = (n == 8) ? 0 : n + 1;
        if (n == 8) got = sh;
        if (n == 8 && first) rd = sh[0];
    end
    // ack own receptions, shift out when read, release otherwise
    always @(negedge scl) begin
        if (n == 8) sdaLow = !(rd && !first);
        else sdaLow = rd && !first && !TXBYTE[7-n];
    end
endmodule
`default_nettype wire

// File: tb_top.sv
/*
  tb_top: master write, master read and slave transfers through the register port.
  Assumes the slave model and the bench's own bit-driven master on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----------------------------------------------------------------
    // bench signals
    // ----------------------------------------------------------------
    logic clock = 0, rst = 1, rxReady = 0;
    logic slaveInhibit = 1, sclM = 0, sdaM = 0;
    sbt_pkg::sbt_sfr_req_t sfrReq = '0;
    logic [7:0] sfrRdData, rxByte, got, v;
    logic sclOe, sdaOe, sdaLow, rxValid, dir;
    wire logic scl = !(sclOe | sclM);
    wire logic sda = !(sdaOe | sdaLow | sdaM);
    int fails = 0, checked = 0, cyc = 0;
    sbt_smbus u_dut (.clock(clock), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .enable(1'b1), .slaveInhibit(slaveInhibit), .addrReadDir(dir), .sclIn(scl), .sclOut(),
        .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .rxValid(rxValid),
        .rxReady(rxReady), .rxByte(rxByte));
    sbt_slave_model u_slave (.scl(scl), .sda(sda), .sdaLow(sdaLow), .got(got));
    initial forever #50 clock = !clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) sfrReq <= {a, 1'b1, 1'b0, d};
        @(posedge clock) sfrReq <= '0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clock) sfrReq <= {a, 1'b0, 1'b1, 8'h00};
        @(posedge clock) sfrReq <= '0;
        #1 v = sfrRdData;
    endtask
    task automatic waitBit(input int b, input logic val);
        for (int i = 0; i < 3000; i++) begin
            rdr(8'hc0);
            if (v[b] === val) break;
        end
    endtask
    task automatic master_write;
        wr(8'hc0, 8'h20);
        waitBit(0, 1'b1);
        chk(v[7], 1'b1);
        wr(8'hc2, 8'h5a);
        wr(8'hc0, 8'h00);
        waitBit(0, 1'b1);
        chk(got, 8'h5a);
        chk(v[1], 1'b1);
        wr(8'hc2, 8'ha5);
        wr(8'hc0, 8'h00);
        waitBit(0, 1'b1);
        chk(got, 8'ha5);
        wr(8'hc0, 8'h10);
        waitBit(7, 1'b0);
        chk(v[7], 1'b0);
        $display("master write done");
    endtask
    task automatic master_read;
        wr(8'hc0, 8'h20);
        waitBit(0, 1'b1);
        wr(8'hc2, 8'h5b);
        wr(8'hc0, 8'h00);
        waitBit(0, 1'b1);
        chk(got, 8'h5b);
        wr(8'hc0, 8'h00);
        waitBit(0, 1'b1);
        chk(v[3], 1'b1);
        chk(v[6], 1'b0);
        rdr(8'hc2);
        chk(v, 8'h96);
        chk(rxValid, 1'b1);
        chk(rxByte, 8'h96);
        @(posedge clock) rxReady <= 1'b1;
        wr(8'hc0, 8'h10);
        waitBit(7, 1'b0);
        chk(v[7], 1'b0);
        $display("master read done");
    endtask
    // ----------------------------------------------------------------
    // bench as bus master
    // ----------------------------------------------------------------
    task automatic mbit(input logic b);
        @(posedge clock) sdaM <= !b;
        repeat (4) @(posedge clock);
        sclM <= 1'b0;
        while (scl !== 1'b1) @(posedge clock);
        repeat (4) @(posedge clock);
        sclM <= 1'b1;
    endtask
    task automatic mbyte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            mbit(d[i]);
        end
    endtask
    task automatic mstart;
        repeat (4) @(posedge clock);
        sdaM <= 1'b1;
        repeat (4) @(posedge clock);
        sclM <= 1'b1;
    endtask
    task automatic mstop;
        @(posedge clock) sdaM <= 1'b1;
        repeat (4) @(posedge clock);
        sclM <= 1'b0;
        repeat (4) @(posedge clock);
        sdaM <= 1'b0;
    endtask
    task automatic slave_transfer;
        @(posedge clock) slaveInhibit <= 1'b0;
        mstart();
        mbyte(8'ha4);
        waitBit(0, 1'b1);
        chk(v[5], 1'b1);
        chk(v[3], 1'b1);
        chk(dir, 1'b0);
        rdr(8'hc2);
        chk(v, 8'ha4);
        wr(8'hc2, 8'hc3);
        wr(8'hc0, 8'h02);
        mbit(1'b1);
        mbyte(8'hff);
        mbit(1'b1);
        waitBit(0, 1'b1);
        chk(v[6], 1'b1);
        chk(v[1], 1'b1);
        chk(got, 8'hc3);
        rdr(8'hc2);
        chk(v, 8'hc3);
        wr(8'hc0, 8'h00);
        rdr(8'hc0);
        chk(v[6], 1'b0);
        mstop();
        waitBit(0, 1'b1);
        chk(v[4], 1'b1);
        wr(8'hc0, 8'h00);
        mstart();
        mbyte(8'ha4);
        waitBit(0, 1'b1);
        wr(8'hc0, 8'h00);
        mbit(1'b1);
        mbyte(8'h11);
        repeat (8) @(posedge clock);
        rdr(8'hc0);
        chk(v[0], 1'b0);
        mbit(1'b1);
        mstop();
        $display("slave transfer done");
    endtask
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        master_write();
        master_read();
        slave_transfer();
        wrap_up();
    end
endmodule
`default_nettype wire
